// >>> design/return_link_burst_formatter.sv
// Overview of operation
// - Four burst kinds: traffic, acquisition, timing, signalling.
// - Burst kind follows current terminal activity.
// - Traffic payload is cells or transport packets.
// - Both payload formats built in, selectable.
// - Cell mode: prefix plus count of 53-byte cells.
// - Packet mode: count of 188-byte packets.
// - Logon signalling reports packet-format traffic capability.
// - Acquisition only at logon: preamble, frequency sequence.
// - Periodic timing bursts, optional access field.
// - Signalling only at logon: identity, capabilities.
// - Timing locked to 27 MHz network reference.
// - Reference extracted by packet identifier filter.
// - Constant coding: reference handled like program clock.
// - Adaptive coding: reference tied to frame N.
// - Forward stream arrives as transport packets.
// - Timing taken only from primary feeder receiver.
// - Contention timing and signalling bursts get CRC-16 over scrambled bits.
`timescale 1ns/10ps
`default_nettype none
module return_link_burst_formatter (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	input  wire logic                                reqValid,
	input  wire burst_formatter_pkg::burst_request_type req,
	output logic                                     reqReady,
	output logic                                     burstRejected,
	input  wire burst_formatter_pkg::burst_config_type cfg,
	input  wire logic                                logonActive,
	input  wire logic [47:0]                         terminalId,
	input  wire logic                                payloadValid,
	input  wire logic [7:0]                          payloadData,
	output logic                                     payloadReady,
	output burst_formatter_pkg::out_byte_type        outByte,
	input  wire logic                                outReady,
	input  wire burst_formatter_pkg::ref_byte_type   refIn,
	input  wire logic                                refFromPrimary,
	input  wire logic [12:0]                         refPid,
	input  wire logic                                acmMode,
	input  wire logic                                frameStart,
	output logic [burst_formatter_pkg::TIME_W-1:0]   localTime,
	output logic                                     timeLocked
);

	// *******************************************************************
	// Helper functions.
	// *******************************************************************

	// Scrambles one byte MSB first; returns the new register and the byte.
	function automatic logic [22:0] scrambleByte(input logic [14:0] prbsIn,
			input logic [7:0] din);
		logic [14:0] p;
		logic [7:0]  d;
		logic        fb;
		p = prbsIn;
		d = din;
		for (int i = 7; i >= 0; i--) begin
			fb = p[13] ^ p[14];
			d[i] = d[i] ^ fb;
			p = {p[13:0], fb};
		end
		return {p, d};
	endfunction

	// Folds one byte into the check code, MSB first.
	function automatic logic [15:0] crcByte(input logic [15:0] crcIn,
			input logic [7:0] din);
		logic [15:0] c;
		c = crcIn;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ din[i]) begin
				c = {c[14:0], 1'b0} ^ burst_formatter_pkg::CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction

	// Turns a 33-bit base and 9-bit extension into linear 27 MHz ticks.
	function automatic logic [41:0] refToTicks(input logic [47:0] raw);
		logic [41:0] base;
		base = {9'h000, raw[47:15]};
		return (base << 8) + (base << 5) + (base << 3) + (base << 2)
			+ {33'h0, raw[8:0]};
	endfunction

	// *******************************************************************
	// State.
	// *******************************************************************
	burst_formatter_pkg::state_type st;
	burst_formatter_pkg::state_type next_st;

	logic [16:0]  tickSum;
	logic [7:0]   pos;
	logic [47:0]  refFull;
	logic [41:0]  refTicks;
	logic [41:0]  waitDiff;
	logic [22:0]  scr;
	logic [7:0]   rawByte;
	logic [47:0]  idShift;
	logic         fromPayload;
	logic         go;
	logic         allowed;
	burst_formatter_pkg::burst_kind_type pickKind;

	// *******************************************************************
	// Next-state logic.
	// *******************************************************************

	// All behaviour lives here; the register below only stores it.
	always_comb begin
		next_st = st;
		next_st.rejected = 1'b0;
		pos = 8'h00;
		refFull = '0;
		refTicks = '0;
		scr = '0;
		rawByte = 8'h00;
		go = 1'b0;
		allowed = 1'b0;
		pickKind = burst_formatter_pkg::KIND_NONE;
		idShift = terminalId << {st.index[2:0], 3'h0};
		waitDiff = st.now - st.startTime;
		fromPayload = (st.kind == burst_formatter_pkg::KIND_TRAFFIC)
			|| (st.kind == burst_formatter_pkg::KIND_TIMING);

		// Local 27 MHz count from a fractional accumulator at 100 MHz.
		tickSum = st.tickAcc + burst_formatter_pkg::TICK_STEP;
		if (tickSum >= burst_formatter_pkg::TICK_WRAP) begin
			next_st.tickAcc = tickSum - burst_formatter_pkg::TICK_WRAP;
			next_st.now = st.now + 42'h1;
		end else begin
			next_st.tickAcc = tickSum;
		end

		// A taken byte frees the output slot.
		if (st.out.valid && outReady) begin
			next_st.out.valid = 1'b0;
		end

		// Frame starts are stamped so a late reference can be tied back.
		if (frameStart) begin
			next_st.sofSnap = {st.sofSnap[1:0], st.now};
			if (st.sofSince != burst_formatter_pkg::SOF_SINCE_MAX) begin
				next_st.sofSince = st.sofSince + 2'h1;
			end
		end

		// Only the receiver parked on the primary feed steers timing.
		if (refIn.valid && refFromPrimary) begin
			pos = refIn.start ? burst_formatter_pkg::POS_SYNC : st.pktPos;
			if (pos != burst_formatter_pkg::POS_MAX) begin
				next_st.pktPos = pos + 8'h01;
			end
			if (pos == burst_formatter_pkg::POS_SYNC) begin
				next_st.pidOk = refIn.data == burst_formatter_pkg::TS_SYNC;
			end else if (pos == burst_formatter_pkg::POS_PID_HI) begin
				next_st.pidOk = st.pidOk && (refIn.data[4:0] == refPid[12:8]);
			end else if (pos == burst_formatter_pkg::POS_PID_LO) begin
				next_st.pidOk = st.pidOk && (refIn.data == refPid[7:0]);
			end
			refFull = {st.refVal[39:0], refIn.data};
			if (st.pidOk && pos >= burst_formatter_pkg::POS_REF_FIRST
					&& pos <= burst_formatter_pkg::POS_REF_LAST) begin
				next_st.refVal = refFull;
			end
			// The MSB marks frame N+2, so the reference frame is two back.
			if (st.pidOk && pos == burst_formatter_pkg::POS_REF_FIRST) begin
				next_st.sofSince = 2'h0;
			end
			refTicks = refToTicks(refFull);
			if (st.pidOk && pos == burst_formatter_pkg::POS_REF_LAST) begin
				if (!acmMode) begin
					next_st.now = refTicks;
					next_st.refSeen = 1'b1;
				end else if (st.sofSince == 2'h0 && !frameStart) begin
					// Elapsed time since frame N is kept, only the offset moves.
					next_st.now = next_st.now + refTicks - st.sofSnap[2];
					next_st.refSeen = 1'b1;
				end
			end
		end

		// Burst sequencer.
		case (st.phase)
			burst_formatter_pkg::PH_IDLE: begin
				next_st.reqReady = 1'b1;
				if (reqValid && st.reqReady) begin
					case (req.activity)
						burst_formatter_pkg::ACT_LOGON_ACQUIRE: begin
							pickKind = burst_formatter_pkg::KIND_ACQUISITION;
							allowed = logonActive;
						end
						burst_formatter_pkg::ACT_LOGON_SIGNAL: begin
							pickKind = burst_formatter_pkg::KIND_SIGNALLING;
							allowed = logonActive;
						end
						burst_formatter_pkg::ACT_KEEP_SYNC: begin
							pickKind = burst_formatter_pkg::KIND_TIMING;
							allowed = 1'b1;
						end
						burst_formatter_pkg::ACT_SEND_DATA: begin
							pickKind = burst_formatter_pkg::KIND_TRAFFIC;
							allowed = 1'b1;
						end
						default: allowed = 1'b0;
					endcase
					if (!allowed) begin
						next_st.rejected = 1'b1;
					end else begin
						next_st.kind = pickKind;
						next_st.startTime = req.startTime;
						next_st.contention = req.contention
							&& (pickKind == burst_formatter_pkg::KIND_TIMING
							|| pickKind == burst_formatter_pkg::KIND_SIGNALLING);
						next_st.preLen = cfg.preambleLen;
						case (pickKind)
							burst_formatter_pkg::KIND_TRAFFIC: begin
								if (cfg.mpegMode) begin
									next_st.bodyLen = 16'(cfg.packetCount)
										* burst_formatter_pkg::TS_BYTES;
								end else begin
									next_st.bodyLen = 16'(cfg.cellCount)
										* burst_formatter_pkg::CELL_BYTES
										+ 16'(cfg.cellPrefixLength);
								end
							end
							burst_formatter_pkg::KIND_ACQUISITION:
								next_st.bodyLen = 16'(cfg.freqSeqLen);
							burst_formatter_pkg::KIND_TIMING:
								next_st.bodyLen = 16'(req.accessLen);
							default:
								next_st.bodyLen = burst_formatter_pkg::CSC_BODY_BYTES;
						endcase
						next_st.index = 16'h0000;
						next_st.crc = burst_formatter_pkg::CRC_INIT;
						next_st.prbs = burst_formatter_pkg::PRBS_SEED;
						next_st.firstPend = 1'b1;
						next_st.reqReady = 1'b0;
						next_st.phase = burst_formatter_pkg::PH_WAIT;
					end
				end
			end
			burst_formatter_pkg::PH_WAIT: begin
				// Signed difference, so the start may lie behind a wrap.
				if (!waitDiff[41]) begin
					next_st.phase = burst_formatter_pkg::PH_PRE;
				end
			end
			burst_formatter_pkg::PH_PRE: begin
				if (st.preLen == 8'h00) begin
					next_st.phase = burst_formatter_pkg::PH_BODY;
				end else if (!st.out.valid) begin
					next_st.out.valid = 1'b1;
					next_st.out.first = st.firstPend;
					next_st.out.kind = st.kind;
					next_st.out.data = burst_formatter_pkg::PREAMBLE_BYTE;
					next_st.firstPend = 1'b0;
					next_st.out.last = (st.index[7:0] == st.preLen - 8'h01)
						&& st.bodyLen == 16'h0000 && !st.contention;
					next_st.index = st.index + 16'h0001;
					if (st.index[7:0] == st.preLen - 8'h01) begin
						next_st.index = 16'h0000;
						next_st.phase = burst_formatter_pkg::PH_BODY;
					end
				end
			end
			burst_formatter_pkg::PH_BODY: begin
				if (st.bodyLen == 16'h0000) begin
					next_st.phase = st.contention ? burst_formatter_pkg::PH_CRC
						: burst_formatter_pkg::PH_IDLE;
				end else begin
					if (fromPayload) begin
						go = st.payloadReady && payloadValid;
						rawByte = payloadData;
					end else begin
						go = !st.out.valid;
						if (st.kind == burst_formatter_pkg::KIND_ACQUISITION) begin
							rawByte = burst_formatter_pkg::FREQ_SEQ_BYTE;
						end else if (st.index < burst_formatter_pkg::CSC_ID_BYTES) begin
							rawByte = idShift[47:40];
						end else begin
							rawByte = burst_formatter_pkg::CAP_BASE
								| burst_formatter_pkg::CAP_MPEG;
						end
					end
					if (go) begin
						scr = scrambleByte(st.prbs, rawByte);
						next_st.prbs = scr[22:8];
						if (st.contention) begin
							next_st.crc = crcByte(st.crc, scr[7:0]);
						end
						next_st.out.valid = 1'b1;
						next_st.out.first = st.firstPend;
						next_st.out.kind = st.kind;
						next_st.out.data = scr[7:0];
						next_st.firstPend = 1'b0;
						next_st.out.last = (st.index == st.bodyLen - 16'h0001)
							&& !st.contention;
						next_st.index = st.index + 16'h0001;
						if (st.index == st.bodyLen - 16'h0001) begin
							next_st.index = 16'h0000;
							next_st.phase = st.contention ? burst_formatter_pkg::PH_CRC
								: burst_formatter_pkg::PH_IDLE;
						end
					end
				end
			end
			burst_formatter_pkg::PH_CRC: begin
				if (!st.out.valid) begin
					next_st.out.valid = 1'b1;
					next_st.out.first = st.firstPend;
					next_st.out.kind = st.kind;
					next_st.out.data = st.index[0] ? st.crc[7:0] : st.crc[15:8];
					next_st.firstPend = 1'b0;
					next_st.out.last = st.index[0];
					next_st.index = st.index + 16'h0001;
					if (st.index[0]) begin
						next_st.index = 16'h0000;
						next_st.phase = burst_formatter_pkg::PH_IDLE;
					end
				end
			end
			default: begin
				next_st.phase = burst_formatter_pkg::PH_IDLE;
			end
		endcase

		// Ready is registered, so a payload byte is only offered an empty slot.
		next_st.payloadReady = (next_st.phase == burst_formatter_pkg::PH_BODY)
			&& (st.phase == burst_formatter_pkg::PH_BODY) && fromPayload
			&& !next_st.out.valid && st.bodyLen != 16'h0000;
	end

	// *******************************************************************
	// State register.
	// *******************************************************************

	// Reset loads constants only; the counter starts free until locked.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.phase <= burst_formatter_pkg::PH_IDLE;
			st.crc <= burst_formatter_pkg::CRC_INIT;
			st.prbs <= burst_formatter_pkg::PRBS_SEED;
		end else begin
			st <= next_st;
		end
	end

	// *******************************************************************
	// Outputs, all straight from the state register.
	// *******************************************************************
	assign reqReady      = st.reqReady;
	assign burstRejected = st.rejected;
	assign payloadReady  = st.payloadReady;
	assign outByte       = st.out;
	assign localTime     = st.now;
	assign timeLocked    = st.refSeen;

endmodule
`default_nettype wire

// >>> design/burst_formatter_pkg.sv
`default_nettype none
package burst_formatter_pkg;

	// *******************************************************************
	// Timing constants.
	// *******************************************************************
	localparam int unsigned SYS_CLOCK_KHZ = 100000;
	localparam int unsigned REF_CLOCK_KHZ = 27000;
	localparam logic [16:0] TICK_STEP     = 17'(REF_CLOCK_KHZ);
	localparam logic [16:0] TICK_WRAP     = 17'(SYS_CLOCK_KHZ);
	localparam int unsigned TIME_W        = 42;

	// *******************************************************************
	// Payload and field layout.
	// *******************************************************************
	localparam logic [15:0] CELL_BYTES     = 16'h0035;
	localparam logic [15:0] TS_BYTES       = 16'h00bc;
	localparam logic [15:0] CSC_ID_BYTES   = 16'h0006;
	localparam logic [15:0] CSC_BODY_BYTES = 16'h0007;
	localparam logic [7:0]  CAP_BASE       = 8'h00;
	localparam logic [7:0]  CAP_MPEG       = 8'h01;
	localparam logic [7:0]  PREAMBLE_BYTE  = 8'hcc;
	localparam logic [7:0]  FREQ_SEQ_BYTE  = 8'h55;

	// *******************************************************************
	// Forward stream parsing of the time reference packet.
	// *******************************************************************
	localparam logic [7:0]  TS_SYNC       = 8'h47;
	localparam logic [7:0]  POS_SYNC      = 8'h00;
	localparam logic [7:0]  POS_PID_HI    = 8'h01;
	localparam logic [7:0]  POS_PID_LO    = 8'h02;
	localparam logic [7:0]  POS_REF_FIRST = 8'h06;
	localparam logic [7:0]  POS_REF_LAST  = 8'h0b;
	localparam logic [7:0]  POS_MAX       = 8'hff;
	localparam logic [1:0]  SOF_SINCE_MAX = 2'h3;

	// *******************************************************************
	// Scrambler and check code.
	// *******************************************************************
	localparam logic [14:0] PRBS_SEED = 15'h4a80;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [15:0] CRC_INIT  = 16'hffff;

	// *******************************************************************
	// Types.
	// *******************************************************************
	typedef enum logic [2:0] {
		ACT_IDLE          = 3'h0,
		ACT_LOGON_ACQUIRE = 3'h1,
		ACT_LOGON_SIGNAL  = 3'h2,
		ACT_KEEP_SYNC     = 3'h3,
		ACT_SEND_DATA     = 3'h4
	} activity_type;

	typedef enum logic [2:0] {
		KIND_NONE        = 3'h0,
		KIND_TRAFFIC     = 3'h1,
		KIND_ACQUISITION = 3'h2,
		KIND_TIMING      = 3'h3,
		KIND_SIGNALLING  = 3'h4
	} burst_kind_type;

	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_WAIT = 5'h02,
		PH_PRE  = 5'h04,
		PH_BODY = 5'h08,
		PH_CRC  = 5'h10
	} phase_type;

	typedef struct packed {
		activity_type        activity;
		logic                contention;
		logic [7:0]          accessLen;
		logic [TIME_W-1:0]   startTime;
	} burst_request_type;

	typedef struct packed {
		logic       mpegMode;
		logic [7:0] cellCount;
		logic [7:0] cellPrefixLength;
		logic [7:0] packetCount;
		logic [7:0] preambleLen;
		logic [7:0] freqSeqLen;
	} burst_config_type;

	typedef struct packed {
		logic       valid;
		logic       start;
		logic [7:0] data;
	} ref_byte_type;

	typedef struct packed {
		logic           valid;
		logic           first;
		logic           last;
		burst_kind_type kind;
		logic [7:0]     data;
	} out_byte_type;

	typedef struct packed {
		phase_type                phase;
		burst_kind_type           kind;
		logic                     contention;
		logic                     firstPend;
		logic [TIME_W-1:0]        startTime;
		logic [15:0]              bodyLen;
		logic [7:0]               preLen;
		logic [15:0]              index;
		logic [15:0]              crc;
		logic [14:0]              prbs;
		out_byte_type             out;
		logic                     reqReady;
		logic                     payloadReady;
		logic                     rejected;
		logic [TIME_W-1:0]        now;
		logic [16:0]              tickAcc;
		logic [7:0]               pktPos;
		logic                     pidOk;
		logic [47:0]              refVal;
		logic [2:0][TIME_W-1:0]   sofSnap;
		logic [1:0]               sofSince;
		logic                     refSeen;
	} state_type;

endpackage
`default_nettype wire

// >>> testbench/burst_formatter_checker.sv
`timescale 1ns/10ps
`default_nettype none
module burst_formatter_checker (
	input wire logic                                   sys_clk,
	input wire logic                                   rst_n,
	input wire logic                                   reqValid,
	input wire burst_formatter_pkg::burst_request_type req,
	input wire logic                                   reqReady,
	input wire logic                                   burstRejected,
	input wire burst_formatter_pkg::burst_config_type  cfg,
	input wire logic                                   logonActive,
	input wire logic                                   payloadReady,
	input wire burst_formatter_pkg::out_byte_type      outByte,
	input wire logic                                   outReady,
	input wire burst_formatter_pkg::ref_byte_type      refIn,
	input wire logic                                   refFromPrimary,
	input wire logic [burst_formatter_pkg::TIME_W-1:0] localTime,
	input wire logic                                   timeLocked
);
	// ****************
	// Port checks.
	// ****************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	burst_formatter_pkg::burst_kind_type want;

	// Kind called for by the last taken request; refused ones never produce bytes.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			want <= burst_formatter_pkg::KIND_NONE;
		else if (reqValid && reqReady)
			case (req.activity)
			burst_formatter_pkg::ACT_LOGON_ACQUIRE: want <= burst_formatter_pkg::KIND_ACQUISITION;
			burst_formatter_pkg::ACT_LOGON_SIGNAL: want <= burst_formatter_pkg::KIND_SIGNALLING;
			burst_formatter_pkg::ACT_KEEP_SYNC: want <= burst_formatter_pkg::KIND_TIMING;
			burst_formatter_pkg::ACT_SEND_DATA: want <= burst_formatter_pkg::KIND_TRAFFIC;
			default: want <= burst_formatter_pkg::KIND_NONE;
			endcase
	end

	sequence s_take;
		reqValid && reqReady;
	endsequence
	sequence s_bad_take;
		s_take ##0 (req.activity == burst_formatter_pkg::ACT_IDLE || (!logonActive &&
			(req.activity == burst_formatter_pkg::ACT_LOGON_ACQUIRE ||
			req.activity == burst_formatter_pkg::ACT_LOGON_SIGNAL)));
	endsequence

	a_bad_refused: assert property (s_bad_take |=> burstRejected && reqReady)
		else $error("request not refused");
	a_data_taken: assert property (s_take ##0 (req.activity == burst_formatter_pkg::ACT_SEND_DATA)
		|=> !reqReady && !burstRejected) else $error("data request not taken");
	a_kind_match: assert property (outByte.valid |-> outByte.kind == want)
		else $error("burst kind differs from activity");
	a_payload_gate: assert property (payloadReady |-> !reqReady &&
		(want == burst_formatter_pkg::KIND_TRAFFIC || want == burst_formatter_pkg::KIND_TIMING))
		else $error("payload read outside traffic or timing body");
	a_preamble_first: assert property (outByte.valid && outByte.first && cfg.preambleLen != 8'h00
		|-> outByte.data == burst_formatter_pkg::PREAMBLE_BYTE) else $error("first byte not preamble");
	a_byte_held: assert property (outByte.valid && !outReady |=> outByte.valid && $stable(outByte))
		else $error("output byte lost while stalled");
	a_time_steady: assert property ((!refIn.valid)[*4] |-> (localTime - $past(localTime)) <= 42'h1)
		else $error("local time jumped without reference");
	a_lock_cause: assert property ($rose(timeLocked) |-> $past(refFromPrimary) || $past(refFromPrimary, 2))
		else $error("lock without primary reference");
	a_idle_quiet: assert property (reqReady |-> !payloadReady
		&& (!outByte.valid || outByte.last)) else $error("activity while idle");
endmodule
`default_nettype wire

// >>> testbench/hub_model.sv
`timescale 1ns/10ps
`default_nettype none
module hub_model (
	input  wire logic                             sys_clk,
	output burst_formatter_pkg::ref_byte_type     refIn,
	output logic                                  refFromPrimary,
	output logic                                  frameStart,
	output logic                                  outReady
);
	// ****************
	// Gateway side.
	// ****************
	int seed = 81559;

	// Constant coding only, so no frame markers are sent.
	initial begin
		refIn = '0;
		refFromPrimary = 1'b0;
		frameStart = 1'b0;
		outReady = 1'b0;
	end

	// The sink stalls on random cycles so that held bytes get exercised.
	always @(posedge sys_clk)
		outReady <= ($random(seed) % 3) != 0;

	// One whole forward packet carrying the time reference; data flips once released.
	task automatic send_ref(input logic [12:0] pid, input logic [32:0] base, input logic [8:0] ext,
		input logic primary);
		logic [7:0] pkt [188];
		logic [47:0] f;
		int i;
		f = {base, 6'h3f, ext};
		for (i = 0; i < 188; i++)
			pkt[i] = 8'hff;
		pkt[0] = burst_formatter_pkg::TS_SYNC;
		pkt[1] = {3'h0, pid[12:8]};
		pkt[2] = pid[7:0];
		for (i = 0; i < 6; i++)
			pkt[6 + i] = f[47 - 8 * i -: 8];
		for (i = 0; i < 188; i++) begin
			@(posedge sys_clk);
			refIn <= '{valid: 1'b1, start: i == 0, data: pkt[i]};
			refFromPrimary <= primary;
		end
		@(posedge sys_clk);
		refIn <= '{valid: 1'b0, start: 1'b0, data: ~pkt[187]};
		refFromPrimary <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	// ****************
	// Stimulus and model.
	// ****************
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reqValid = 1'b0;
	logic logonActive = 1'b0;
	logic payloadValid = 1'b1;
	logic acmMode = 1'b0;
	logic [7:0] payloadData = 8'h00;
	logic [47:0] terminalId = 48'h0;
	burst_formatter_pkg::burst_request_type req = '0;
	burst_formatter_pkg::burst_config_type cfg = '0;
	burst_formatter_pkg::out_byte_type outByte;
	burst_formatter_pkg::ref_byte_type refIn;
	logic reqReady, burstRejected, payloadReady, outReady, refFromPrimary, frameStart, timeLocked;
	logic [41:0] localTime, mark, want;
	logic [32:0] base;
	int seed = 81559;
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int i;
	int rAct[4] = '{1, 2, 0, 7};
	int tAct[7] = '{1, 2, 3, 3, 4, 4, 4};
	int tCont[7] = '{0, 1, 0, 1, 1, 0, 0};
	int tAcc[7] = '{0, 0, 3, 2, 0, 0, 0};
	int tMpeg[7] = '{0, 0, 0, 0, 0, 0, 1};
	int tPre[7] = '{0, 0, 0, 0, 2, 0, 0};
	int tCnt[7] = '{0, 0, 0, 0, 2, 1, 2};

	return_link_burst_formatter return_link_burst_formatter_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.reqValid(reqValid), .req(req), .reqReady(reqReady), .burstRejected(burstRejected),
		.cfg(cfg), .logonActive(logonActive), .terminalId(terminalId),
		.payloadValid(payloadValid), .payloadData(payloadData), .payloadReady(payloadReady),
		.outByte(outByte), .outReady(outReady), .refIn(refIn), .refFromPrimary(refFromPrimary),
		.refPid(13'h0123), .acmMode(acmMode), .frameStart(frameStart), .localTime(localTime),
		.timeLocked(timeLocked));
	hub_model hub_model_i (.sys_clk(sys_clk), .refIn(refIn), .refFromPrimary(refFromPrimary),
		.frameStart(frameStart), .outReady(outReady));

	// Free-running clock and random payload bytes.
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		payloadData <= 8'($random(seed));

	// A hang is cut short well beyond the expected few thousand cycles.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			$display("[ERR] %0t timeout", $time);
			results();
		end
	end

	task check(input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Request is held until the edge that samples ready high.
	task automatic request(input int act, input logic cont, input int acc);
		@(posedge sys_clk);
		reqValid <= 1'b1;
		req <= '{activity: burst_formatter_pkg::activity_type'(act[2:0]), contention: cont,
			accessLen: 8'(acc), startTime: localTime + 42'd30};
		@(posedge sys_clk);
		while (reqReady !== 1'b1)
			@(posedge sys_clk);
		reqValid <= 1'b0;
	endtask

	// Expected lengths come from the byte counts of each burst kind.
	task automatic burst(input int act, input logic cont, input int acc);
		int n;
		int got;
		int pay;
		int total;
		int body, k, j;
		logic [7:0] b, q[$];
		logic [14:0] p;
		logic [15:0] c;
		logic [41:0] st;
		n = 0;
		got = 0;
		p = burst_formatter_pkg::PRBS_SEED;
		c = burst_formatter_pkg::CRC_INIT;
		request(act, cont, acc);
		st = req.startTime;
		pay = act != 4 ? (act == 3 ? acc : 0) : cfg.mpegMode ? cfg.packetCount * 188
			: cfg.cellPrefixLength + cfg.cellCount * 53;
		body = act == 1 ? cfg.freqSeqLen : act == 2 ? 7 : pay;
		total = cfg.preambleLen + body + (cont && (act == 2 || act == 3) ? 2 : 0);
		while (n < total) begin
			@(posedge sys_clk);
			if (payloadValid && payloadReady) begin
				got++;
				q.push_back(payloadData);
			end
			if (outByte.valid && outReady) begin
				if (n == 0)
					check(localTime >= st, 1);
				check(outByte.kind, act == 4 ? 1 : act == 1 ? 2 : act == 2 ? 4 : 3);
				check(outByte.first, n == 0);
				check(outByte.last, n == total - 1);
				k = n - cfg.preambleLen;
				if (n < cfg.preambleLen)
					check(outByte.data, burst_formatter_pkg::PREAMBLE_BYTE);
				else if (k < body) begin
					b = act == 1 ? 8'h55 : act != 2 ? q.pop_front()
						: k < 6 ? terminalId[47 - 8 * k -: 8] : 8'h01;
					for (j = 7; j >= 0; j--) begin
						b[j] ^= p[13] ^ p[14];
						p = {p[13:0], p[13] ^ p[14]};
						c = {c[14:0], 1'b0}
							^ (c[15] ^ b[j] ? burst_formatter_pkg::CRC_POLY : 16'h0);
					end
					check(outByte.data, b);
				end else
					check(outByte.data, k == body ? c[15:8] : c[7:0]);
				n++;
			end
		end
		check(got, pay);
	endtask

	// Reset, reference lock, refusals, then every burst kind in a table.
	initial begin
		terminalId = 48'({$random(seed), $random(seed)});
		base = {1'b1, 32'($random(seed))};
		repeat (6) @(posedge sys_clk);
		check(reqReady, 0);
		check(timeLocked, 0);
		check(localTime, 0);
		check(outByte, 0);
		rst_n <= 1'b1;
		hub_model_i.send_ref(13'h0123, base, 9'h12b, 1'b0);
		hub_model_i.send_ref(13'h0124, base, 9'h12b, 1'b1);
		check(timeLocked, 0);
		hub_model_i.send_ref(13'h0123, base, 9'h12b, 1'b1);
		want = 42'(base) * 42'd300 + 42'h12b;
		check(timeLocked, 1);
		check(localTime - want >= 45 && localTime - want <= 51, 1);
		mark = localTime;
		repeat (1000) @(posedge sys_clk);
		check(localTime - mark, 42'd270);
		for (i = 0; i < 4; i++) begin
			request(rAct[i], 1'b0, 0);
			@(posedge sys_clk);
			check(burstRejected, 1);
			check(reqReady, 1);
		end
		logonActive <= 1'b1;
		for (i = 0; i < 7; i++) begin
			cfg <= '{mpegMode: tMpeg[i][0], cellCount: 8'(tCnt[i]), cellPrefixLength: 8'(tPre[i]),
				packetCount: 8'(tCnt[i]), preambleLen: 8'(1 + ($random(seed) & 3)),
				freqSeqLen: 8'h05};
			burst(tAct[i], tCont[i][0], tAcc[i]);
		end
		results();
	end
endmodule

bind return_link_burst_formatter burst_formatter_checker chk_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .reqValid(reqValid), .req(req), .reqReady(reqReady),
	.burstRejected(burstRejected), .cfg(cfg), .logonActive(logonActive),
	.payloadReady(payloadReady), .outByte(outByte), .outReady(outReady), .refIn(refIn),
	.refFromPrimary(refFromPrimary), .localTime(localTime), .timeLocked(timeLocked));
`default_nettype wire
